/* hdl/rcl_pkg.sv */
// Package: register map, field layout, decode codes and timing of the reset configuration latches
package rcl_pkg;
   // Register indices; byte address is four times the index
   localparam logic [1:0]  RCL_IDX_PORT_MODE_LOW  = 2'h0;
   localparam logic [1:0]  RCL_IDX_PORT_MODE_HIGH = 2'h1;
   localparam logic [1:0]  RCL_IDX_RESET_PIN      = 2'h2;
   localparam logic [1:0]  RCL_IDX_BOOT_DEBUG     = 2'h3;
   localparam logic [11:0] RCL_ADDR_LATCH_BASE    = 12'h000;
   localparam logic [11:0] RCL_ADDR_STATUS        = 12'h010;
   localparam logic [11:0] RCL_ADDR_ECC_LOG       = 12'h014;
   localparam logic [11:0] RCL_ADDR_ECC_CTRL      = 12'h018;
   localparam int          RCL_NUM_BYTES          = 4;
   localparam int          RCL_NUM_PORTS          = 9;
   // Byte 2 fields
   localparam int          RCL_RESET_PIN_BIT      = 7;
   // Byte 3 fields
   localparam int          RCL_BOOT_SPEED_BIT     = 0;
   localparam int          RCL_DEBUG_SEL_LSB      = 1;
   localparam int          RCL_ECC_EN_BIT         = 3;
   localparam int          RCL_PHASE_LSB          = 4;
   // Factory defaults
   localparam logic [7:0]  RCL_DEF_BYTE0          = 8'h00;
   localparam logic [7:0]  RCL_DEF_BYTE1          = 8'h00;
   localparam logic [7:0]  RCL_DEF_BYTE2          = 8'h00;
   localparam logic [7:0]  RCL_DEF_BYTE3          = 8'h02;
   // Port drive-mode codes
   localparam logic [1:0]  RCL_DM_HIZ_ANALOG      = 2'h0;
   localparam logic [1:0]  RCL_DM_HIZ_DIGITAL     = 2'h1;
   localparam logic [1:0]  RCL_DM_PULL_UP         = 2'h2;
   localparam logic [1:0]  RCL_DM_PULL_DOWN       = 2'h3;
   // Debug port codes
   localparam logic [1:0]  RCL_DBG_JTAG5          = 2'h0;
   localparam logic [1:0]  RCL_DBG_JTAG4          = 2'h1;
   localparam logic [1:0]  RCL_DBG_SWD            = 2'h2;
   localparam logic [1:0]  RCL_DBG_OFF            = 2'h3;
   // Boot oscillator choices
   localparam int          RCL_BOOT_SLOW_MHZ      = 12;
   localparam int          RCL_BOOT_FAST_MHZ      = 48;
   // ECC word size in bytes
   localparam int          RCL_ECC_WORD_BYTES     = 8;
   localparam int          RCL_ECC_DATA_BITS      = RCL_ECC_WORD_BYTES * 8;
   localparam int          RCL_ECC_CHK_BITS       = 8;
   // Timing: latch programming time
   localparam int          RCL_CLK_MHZ            = 100;
   localparam int          RCL_PROG_TIME_US       = 10;
   localparam int          RCL_PROG_CYCLES        = RCL_PROG_TIME_US * RCL_CLK_MHZ;
   // Control register fields
   localparam int          RCL_CTRL_ERR_INT_EN    = 0;
   localparam int          RCL_CTRL_CLR_LOG       = 1;
   typedef enum logic [1:0] {
      RCL_ST_LOAD = 2'b00,
      RCL_ST_RUN  = 2'b01,
      RCL_ST_PROG = 2'b10
   } rcl_state_t;
endpackage

/* hdl/rcl_ecc_secded.sv */
// SECDED corrector for one eight-byte flash word
`timescale 1ns/1ns
`default_nettype none
module rcl_ecc_secded
   import rcl_pkg::*;
(
   // Enable
   input  wire logic                         enable,
   // Word in
   input  wire logic [RCL_ECC_DATA_BITS-1:0] data_in,
   input  wire logic [RCL_ECC_CHK_BITS-1:0]  check_in,
   // Word out
   output logic      [RCL_ECC_DATA_BITS-1:0] data_out,
   output logic                              single_err,
   output logic                              double_err
);
   // Hamming over positions 1..71 (power-of-two positions are check bits), bit 7 overall parity
   function automatic logic [6:0] rcl_data_pos(input int idx);
      int p;
      int n;
      p = 0;
      n = 0;
      for (int k = 1; k < 128; k++) begin
         if ((k & (k - 1)) != 0) begin
            if (n == idx) begin
               p = k;
            end
            n = n + 1;
         end
      end
      return p[6:0];
   endfunction

   logic [6:0] syn_calc;
   logic [6:0] syndrome;
   logic       parity;

   always_comb begin
      syn_calc = 7'h00;
      for (int i = 0; i < RCL_ECC_DATA_BITS; i++) begin
         if (data_in[i]) begin
            syn_calc = syn_calc ^ rcl_data_pos(i);
         end
      end
   end

   assign syndrome = syn_calc ^ check_in[6:0];
   assign parity   = (^data_in) ^ (^check_in);
   assign single_err = enable && parity;
   assign double_err = enable && !parity && (syndrome != 7'h00);

   genvar g;
   generate
      for (g = 0; g < RCL_ECC_DATA_BITS; g++) begin : g_fix
         assign data_out[g] = data_in[g] ^ (single_err && (syndrome == rcl_data_pos(g)));
      end
   endgenerate
endmodule
`default_nettype wire

/* hdl/rcl_top.sv */
// Reset configuration latch array with APB access and flash ECC word checking
//
// The implementer's own choice: the APB register port.
`timescale 1ns/1ns
`default_nettype none
module rcl_top
   import rcl_pkg::*;
#(
   parameter int          PROG_CYCLES   = RCL_PROG_CYCLES,
   parameter int          NUM_PORTS     = RCL_NUM_PORTS,
   parameter logic [7:0]  DEF_BYTE2     = RCL_DEF_BYTE2
)(
   // Clock and reset
   input  wire logic                         pclk,
   input  wire logic                         presetn,
   // APB slave
   input  wire logic                         psel,
   input  wire logic                         penable,
   input  wire logic                         pwrite,
   input  wire logic [11:0]                  paddr,
   input  wire logic [31:0]                  pwdata,
   output logic      [31:0]                  prdata,
   output logic                              pready,
   output logic                              pslverr,
   // Device reset phase in progress
   input  wire logic                         dev_in_reset,
   // Configuration outputs
   output logic      [2*rcl_pkg::RCL_NUM_PORTS-1:0] port_reset_drive_mode,
   output logic      [rcl_pkg::RCL_NUM_PORTS-1:0]   port_pull_up,
   output logic      [rcl_pkg::RCL_NUM_PORTS-1:0]   port_pull_down,
   output logic      [rcl_pkg::RCL_NUM_PORTS-1:0]   port_digital_in,
   output logic                              reset_pin_select,
   output logic                              boot_clock_speed,
   output logic                              debug_jtag5,
   output logic                              debug_jtag4,
   output logic                              debug_swd,
   output logic                              ecc_area_enable,
   output logic      [3:0]                   digital_clock_phase_delay,
   // Flash word check
   input  wire logic                         flash_valid,
   input  wire logic [rcl_pkg::RCL_ECC_DATA_BITS-1:0] flash_data,
   input  wire logic [rcl_pkg::RCL_ECC_CHK_BITS-1:0]  flash_check,
   output logic      [rcl_pkg::RCL_ECC_DATA_BITS-1:0] flash_data_out,
   output logic                              flash_out_valid,
   output logic                              ecc_error_event
);
   import rcl_pkg::*;

   if (NUM_PORTS != RCL_NUM_PORTS || PROG_CYCLES < 1 || PROG_CYCLES > 32'h0000FFFF) begin : g_bad
      $error("rcl_top: unsupported parameter value");
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Storage
   // Nonvolatile image; survives presetn like the real cells, defaults at power-up only
   logic [7:0]  nvl_r [RCL_NUM_BYTES] = '{RCL_DEF_BYTE0, RCL_DEF_BYTE1, DEF_BYTE2, RCL_DEF_BYTE3};
   logic [7:0]  act_r [RCL_NUM_BYTES];     // snapshot applied at reset
   rcl_state_t  state_r, state_nxt;
   logic [15:0] prog_cnt_r;
   logic [1:0]  prog_idx_r;
   logic [7:0]  prog_val_r;
   logic [15:0] write_count_r;
   logic [15:0] single_cnt_r;
   logic [15:0] double_cnt_r;
   logic        err_int_en_r;
   logic        dev_in_reset_q;

   ////////////////////////////////////////////////////////////////////////////////
   // APB decode
   wire         acc       = psel && penable;
   wire         wr_acc    = acc && pwrite && pready;
   wire         hit_latch = (paddr[11:4] == RCL_ADDR_LATCH_BASE[11:4]) && (paddr[1:0] == 2'h0);
   wire  [1:0]  lat_idx   = paddr[3:2];
   wire         hit_stat  = (paddr == RCL_ADDR_STATUS);
   wire         hit_log   = (paddr == RCL_ADDR_ECC_LOG);
   wire         hit_ctrl  = (paddr == RCL_ADDR_ECC_CTRL);
   wire         hit_any   = hit_latch || hit_stat || hit_log || hit_ctrl;
   wire         busy      = (state_r == RCL_ST_PROG);
   wire         lat_wr    = wr_acc && hit_latch && !busy;
   wire         prog_done = busy && (prog_cnt_r == 16'h0001);
   // Latch writes wait out a running programming cycle, else the new byte would be lost
   wire         wr_hold   = pwrite && hit_latch && busy && !prog_done;

   // Releasing reset snapshots the stored image; RUN holds it until the next reset
   wire         rst_rel   = dev_in_reset_q && !dev_in_reset;

   always_comb begin
      state_nxt = state_r;
      unique case (state_r)
         RCL_ST_LOAD: state_nxt = RCL_ST_RUN;
         RCL_ST_RUN:  state_nxt = lat_wr ? RCL_ST_PROG : RCL_ST_RUN;
         RCL_ST_PROG: state_nxt = prog_done ? RCL_ST_RUN : RCL_ST_PROG;
         default:     state_nxt = RCL_ST_LOAD;
      endcase
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state_r        <= RCL_ST_LOAD;
         dev_in_reset_q <= 1'b0;
      end else begin
         state_r        <= state_nxt;
         dev_in_reset_q <= dev_in_reset;
      end
   end

   // Programming timer: the latch cells only take new data after the write time
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prog_cnt_r <= 16'h0000;
         prog_idx_r <= 2'h0;
         prog_val_r <= 8'h00;
      end else if (lat_wr) begin
         prog_cnt_r <= PROG_CYCLES[15:0];
         prog_idx_r <= lat_idx;
         prog_val_r <= pwdata[7:0];
      end else if (busy) begin
         prog_cnt_r <= prog_cnt_r - 16'h0001;
      end
   end

   genvar b;
   generate
      for (b = 0; b < RCL_NUM_BYTES; b++) begin : g_byte
         always_ff @(posedge pclk) begin
            if (prog_done && prog_idx_r == b[1:0]) begin
               nvl_r[b] <= prog_val_r;
            end
         end
         // Snapshot taken on each device reset, held otherwise
         always_ff @(posedge pclk) begin
            if (state_r == RCL_ST_LOAD || rst_rel) begin
               act_r[b] <= nvl_r[b];
            end
         end
      end
   endgenerate

   // Wear counter so software can see how often the array was rewritten
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         write_count_r <= 16'h0000;
      end else if (prog_done && write_count_r != 16'hFFFF) begin
         write_count_r <= write_count_r + 16'h0001;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Decode of the applied snapshot
   function automatic logic [1:0] rcl_port_field(input int p, input logic [7:0] a [RCL_NUM_BYTES]);
      logic [7:0] byt;
      byt = (p < 8) ? a[p/4] : a[2];
      return (p < 8) ? byt[(p%4)*2 +: 2] : byt[(p-8)*2 +: 2];
   endfunction

   logic [2*RCL_NUM_PORTS-1:0] dm_w;
   genvar p;
   generate
      for (p = 0; p < RCL_NUM_PORTS; p++) begin : g_port
         assign dm_w[2*p +: 2] = rcl_port_field(p, act_r);
      end
   endgenerate

   wire [1:0] dbg_w   = act_r[3][RCL_DEBUG_SEL_LSB +: 2];
   wire       ecc_on  = act_r[3][RCL_ECC_EN_BIT];

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         port_reset_drive_mode     <= '0;
         port_pull_up              <= '0;
         port_pull_down            <= '0;
         port_digital_in           <= '0;
         reset_pin_select          <= 1'b0;
         boot_clock_speed          <= 1'b0;
         debug_jtag5               <= 1'b0;
         debug_jtag4               <= 1'b0;
         debug_swd                 <= 1'b0;
         ecc_area_enable           <= 1'b0;
         digital_clock_phase_delay <= 4'h0;
      end else begin
         port_reset_drive_mode <= dm_w;
         for (int i = 0; i < RCL_NUM_PORTS; i++) begin
            // Drive mode only acts while the device is held in reset
            port_pull_up[i]    <= dev_in_reset && dm_w[2*i +: 2] == RCL_DM_PULL_UP;
            port_pull_down[i]  <= dev_in_reset && dm_w[2*i +: 2] == RCL_DM_PULL_DOWN;
            port_digital_in[i] <= dev_in_reset && dm_w[2*i +: 2] == RCL_DM_HIZ_DIGITAL;
         end
         reset_pin_select          <= act_r[2][RCL_RESET_PIN_BIT];
         boot_clock_speed          <= act_r[3][RCL_BOOT_SPEED_BIT];
         debug_jtag5               <= (dbg_w == RCL_DBG_JTAG5);
         debug_jtag4               <= (dbg_w == RCL_DBG_JTAG4);
         debug_swd                 <= (dbg_w == RCL_DBG_SWD);
         ecc_area_enable           <= ecc_on;
         digital_clock_phase_delay <= act_r[3][RCL_PHASE_LSB +: 4];
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Flash ECC check
   logic [RCL_ECC_DATA_BITS-1:0] fix_w;
   logic                         sgl_w;
   logic                         dbl_w;

   rcl_ecc_secded u_ecc (
      .enable     (ecc_area_enable),
      .data_in    (flash_data),
      .check_in   (flash_check),
      .data_out   (fix_w),
      .single_err (sgl_w),
      .double_err (dbl_w)
   );

   wire sgl_hit = flash_valid && sgl_w;
   wire dbl_hit = flash_valid && dbl_w;
   wire clr_log = wr_acc && hit_ctrl && pwdata[RCL_CTRL_CLR_LOG];

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         flash_data_out  <= '0;
         flash_out_valid <= 1'b0;
         ecc_error_event <= 1'b0;
         single_cnt_r    <= 16'h0000;
         double_cnt_r    <= 16'h0000;
         err_int_en_r    <= 1'b0;
      end else begin
         flash_data_out  <= fix_w;
         flash_out_valid <= flash_valid;
         ecc_error_event <= err_int_en_r && (sgl_hit || dbl_hit);
         // A new error in the clearing cycle is still counted
         single_cnt_r <= (clr_log ? 16'h0000 : single_cnt_r) + {15'h0000, sgl_hit};
         double_cnt_r <= (clr_log ? 16'h0000 : double_cnt_r) + {15'h0000, dbl_hit};
         if (wr_acc && hit_ctrl) begin
            err_int_en_r <= pwdata[RCL_CTRL_ERR_INT_EN];
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // APB read and response
   wire [31:0] rd_w = hit_latch ? {24'h000000, nvl_r[lat_idx]} :
                      hit_stat  ? {write_count_r, 14'h0000, busy, ecc_on} :
                      hit_log   ? {double_cnt_r, single_cnt_r} :
                      hit_ctrl  ? {31'h00000000, err_int_en_r} : 32'h00000000;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata  <= 32'h00000000;
         pready  <= 1'b0;
         pslverr <= 1'b0;
      end else begin
         // Registered answer: ready in the first access cycle unless a latch write must wait
         pready  <= psel && !(acc && pready) && !wr_hold;
         pslverr <= psel && !penable && !hit_any;
         prdata  <= (psel && !penable && !pwrite) ? rd_w : prdata;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Checks
   property p_snap_hold;
      @(posedge pclk) disable iff (!presetn)
      (state_r == RCL_ST_RUN && !rst_rel) |=> $stable(act_r[3]);
   endproperty
   a_snap_hold: assert property (p_snap_hold) else $error("snapshot changed outside reset");

   property p_pull_up;
      @(posedge pclk) disable iff (!presetn)
      (dev_in_reset && dm_w[5:4] == RCL_DM_PULL_UP) |=> port_pull_up[2] && !port_pull_down[2];
   endproperty
   a_pull_up: assert property (p_pull_up) else $error("pull-up not applied");

   property p_no_drive_out;
      @(posedge pclk) disable iff (!presetn)
      !dev_in_reset |=> (port_pull_up == '0) && (port_pull_down == '0);
   endproperty
   a_no_drive_out: assert property (p_no_drive_out) else $error("drive mode outside reset");

   property p_reset_pin;
      @(posedge pclk) disable iff (!presetn)
      state_r == RCL_ST_RUN |=> reset_pin_select == $past(act_r[2][RCL_RESET_PIN_BIT]);
   endproperty
   a_reset_pin: assert property (p_reset_pin) else $error("reset pin select wrong");

   property p_boot_speed;
      @(posedge pclk) disable iff (!presetn)
      state_r == RCL_ST_RUN |=> boot_clock_speed == $past(act_r[3][RCL_BOOT_SPEED_BIT]);
   endproperty
   a_boot_speed: assert property (p_boot_speed) else $error("boot speed wrong");

   property p_debug_onehot;
      @(posedge pclk) disable iff (!presetn)
      state_r == RCL_ST_RUN |=> $countones({debug_jtag5, debug_jtag4, debug_swd}) ==
                                ($past(dbg_w) != RCL_DBG_OFF);
   endproperty
   a_debug_onehot: assert property (p_debug_onehot) else $error("debug select wrong");

   property p_ecc_off;
      @(posedge pclk) disable iff (!presetn)
      (!ecc_area_enable && flash_valid) |=> flash_data_out == $past(flash_data) && !ecc_error_event;
   endproperty
   a_ecc_off: assert property (p_ecc_off) else $error("ECC acted while disabled");

   property p_phase;
      @(posedge pclk) disable iff (!presetn)
      state_r == RCL_ST_RUN |=> digital_clock_phase_delay == $past(act_r[3][7:4]);
   endproperty
   a_phase: assert property (p_phase) else $error("phase delay wrong");

   sequence s_prog_start;
      lat_wr;
   endsequence
   sequence s_prog_busy;
      busy [*2];
   endsequence
   property p_prog;
      @(posedge pclk) disable iff (!presetn)
      s_prog_start |=> s_prog_busy or (busy ##1 !busy);
   endproperty
   a_prog: assert property (p_prog) else $error("latch programming did not start");

   property p_wr_not_lost;
      @(posedge pclk) disable iff (!presetn)
      (acc && pready && pwrite && hit_latch) |-> !busy;
   endproperty
   a_wr_not_lost: assert property (p_wr_not_lost) else $error("latch write taken while busy");

   property p_prog_store;
      @(posedge pclk) disable iff (!presetn)
      prog_done |=> nvl_r[prog_idx_r] == $past(prog_val_r);
   endproperty
   a_prog_store: assert property (p_prog_store) else $error("latch byte not stored");
endmodule
`default_nettype wire

/* sim/rcl_far_model.sv */
// Far-side model: device reset phase and flash word source
`timescale 1ns/1ns
`default_nettype none
module rcl_far_model (
   // Clock and reset
   input  wire logic        pclk,
   input  wire logic        presetn,
   // Requests from bench
   input  wire logic        hold_req,
   input  wire logic        send_req,
   input  wire logic [63:0] word,
   // Toward the block
   output logic             dev_in_reset,
   output logic             flash_valid,
   output logic      [63:0] flash_data,
   output logic      [7:0]  flash_check
);
   // Reset phase outlasts presetn so drive modes stay visible
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) dev_in_reset <= 1'b1;
      else dev_in_reset <= hold_req;
   end
   // Idle word lines toggle so a stale word is never reused
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         flash_valid <= 1'b0;
         flash_data  <= 64'h0;
         flash_check <= 8'h00;
      end else begin
         flash_valid <= send_req;
         flash_data  <= send_req ? word : ~flash_data;
         flash_check <= send_req ? 8'h00 : ~flash_check;
      end
   end
endmodule
`default_nettype wire

/* sim/rcl_top_bench.sv */
// Self-checking bench for the reset configuration latches
`timescale 1ns/1ns
`default_nettype none
module rcl_top_bench;
   import rcl_pkg::*;
   logic pclk, presetn, psel, penable, pwrite, pready, pslverr, hold_req, send_req;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, rd;
   logic rerr, dir, rsel, spd, ecc, jt5, jt4, swd, fval, fout_v, err_ev;
   logic [63:0] word, fdata, fout;
   logic [7:0] fchk;
   logic [3:0] phase;
   logic [17:0] mode;
   logic [8:0] pu, pd, di;
   int error_cnt, check_count, cyc;
   rcl_top #(.PROG_CYCLES(4)) u_rcl_top (.pclk(pclk), .presetn(presetn), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .dev_in_reset(dir), .port_reset_drive_mode(mode),
      .port_pull_up(pu), .port_pull_down(pd), .port_digital_in(di), .reset_pin_select(rsel),
      .boot_clock_speed(spd), .debug_jtag5(jt5), .debug_jtag4(jt4), .debug_swd(swd),
      .ecc_area_enable(ecc), .digital_clock_phase_delay(phase), .flash_valid(fval),
      .flash_data(fdata), .flash_check(fchk), .flash_data_out(fout),
      .flash_out_valid(fout_v), .ecc_error_event(err_ev));
   rcl_far_model u_rcl_far_model (.pclk(pclk), .presetn(presetn), .hold_req(hold_req),
      .send_req(send_req), .word(word), .dev_in_reset(dir), .flash_valid(fval),
      .flash_data(fdata), .flash_check(fchk));
   ////////////////////////////////////////////////////////////////////////////////////
   task automatic final_report();
      $display("checks=%0d errors=%0d", check_count, error_cnt);
      if (error_cnt == 0 && check_count > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      check_count++;
      if (got !== exp) begin
         $display("Error t=%0t got=%h exp=%h", $time, got, exp);
         error_cnt++;
      end
   endtask
   // Request held until pready seen high at a rising edge
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      @(posedge pclk);
      psel <= 1'b1; pwrite <= w; paddr <= a; pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      @(posedge pclk);
      while (pready !== 1'b1) @(posedge pclk);
      rd = prdata;
      rerr = pslverr;
      psel <= 1'b0; penable <= 1'b0;
   endtask
   task automatic do_reset();
      hold_req <= 1'b1; presetn <= 1'b0;
      repeat (4) @(posedge pclk);
      presetn <= 1'b1;
      repeat (3) @(posedge pclk);
   endtask
   // Poll the busy bit so a reset never cuts a programming cycle short
   task automatic wait_idle();
      apb(1'b0, RCL_ADDR_STATUS, 32'h0);
      while (rd[1] !== 1'b0) apb(1'b0, RCL_ADDR_STATUS, 32'h0);
   endtask
   task automatic flash_word(input logic [63:0] w);
      @(posedge pclk);
      word <= w;
      send_req <= 1'b1;
      @(posedge pclk);
      send_req <= 1'b0;
      @(negedge pclk);
      while (fout_v !== 1'b1) @(negedge pclk);
   endtask
   task automatic t_defaults();
      for (int i = 0; i < 4; i++) begin
         apb(1'b0, 12'(4 * i), 32'h0);
         chk(rd, (i == 3) ? 32'h02 : 32'h00);
      end
      chk({26'h0, jt5, jt4, swd, ecc, spd, rsel}, 32'h10);
      chk(32'(di | pu | pd), 32'h0);
      flash_word(64'h1);
      chk(fout[31:0], 32'h1);
      chk(32'(err_ev), 32'h0);
      $display("defaults done");
   endtask
   task automatic t_program();
      apb(1'b1, 12'h000, 32'hE4);
      apb(1'b1, 12'h004, 32'h1B);
      apb(1'b1, 12'h008, 32'h8E);
      chk(32'(mode), 32'h0);
      chk(32'(rsel), 32'h0);
      apb(1'b0, RCL_ADDR_STATUS, 32'h0);
      chk(rd, 32'h00020002);
      wait_idle();
      chk(rd, 32'h00030000);
      apb(1'b0, 12'h008, 32'h0);
      chk(rd, 32'h8E);
      do_reset();
      chk(32'(mode), 32'h21BE4);
      chk(32'(pu), 32'h124);
      chk(32'(pd), 32'h018);
      chk(32'(di), 32'h042);
      chk(32'(rsel), 32'h1);
      hold_req <= 1'b0;
      repeat (4) @(posedge pclk);
      chk(32'(pu | pd | di), 32'h0);
      chk(32'(mode), 32'h21BE4);
      $display("program done");
   endtask
   task automatic t_byte3();
      logic [7:0] b;
      // One rewrite per code keeps wear low
      for (int i = 0; i < 4; i++) begin
         b = {4'(4 * i + 3), i[0], i[1:0], i[1]};
         apb(1'b1, 12'h00C, {24'h0, b});
         wait_idle();
         do_reset();
         chk({29'h0, jt5, jt4, swd}, 32'(4 >> i));
         chk(32'(spd), 32'(i[1]));
         chk(32'(ecc), 32'(i[0]));
         chk(32'(phase), 32'(4 * i + 3));
      end
      $display("byte3 done");
   endtask
   task automatic t_flash();
      apb(1'b1, 12'h018, 32'h1);
      flash_word(64'h0);
      chk(fout[31:0], 32'h0);
      chk(32'(err_ev), 32'h0);
      flash_word(64'h0000010000000000);
      chk(fout[63:32], 32'h0);
      chk(fout[31:0], 32'h0);
      chk(32'(err_ev), 32'h1);
      flash_word(64'h3);
      chk(fout[31:0], 32'h3);
      chk(32'(err_ev), 32'h1);
      apb(1'b0, 12'h014, 32'h0);
      chk(rd, 32'h00010001);
      apb(1'b1, 12'h018, 32'h3);
      apb(1'b0, 12'h014, 32'h0);
      chk(rd, 32'h0);
      apb(1'b0, 12'h018, 32'h0);
      chk(rd, 32'h1);
      $display("flash done");
   endtask
   task automatic t_unmapped();
      apb(1'b0, 12'h020, 32'h0);
      chk({31'h0, rerr}, 32'h1);
      chk(rd, 32'h0);
      apb(1'b1, 12'h020, 32'h55);
      chk({31'h0, rerr}, 32'h1);
      apb(1'b0, 12'h000, 32'h0);
      chk(rd, 32'hE4);
      chk({31'h0, rerr}, 32'h0);
      $display("unmapped done");
   endtask
   ////////////////////////////////////////////////////////////////////////////////////
   initial begin
      pclk = 1'b0;
      forever #5 pclk = ~pclk;
   end
   always @(posedge pclk) begin
      cyc++;
      if (cyc == 20000) begin
         error_cnt++;
         final_report();
      end
   end
   initial begin
      presetn = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0; paddr = 12'h000;
      pwdata = 32'h0; hold_req = 1'b1; send_req = 1'b0; word = 64'h0;
      repeat (4) @(posedge pclk);
      presetn <= 1'b1;
      repeat (3) @(posedge pclk);
      t_defaults();
      t_program();
      t_unmapped();
      t_byte3();
      t_flash();
      final_report();
   end
endmodule
`default_nettype wire
